// >>> core/isc_pkg.sv
package isc_pkg;
  localparam int N_IN_DEF = 8;
  localparam int N_MC_DEF = 12;
  localparam int RING_DEF = 6;
  localparam int PT_PER_MC = 8;
  localparam int PT_PER_GRP = 4;
  localparam int LIT_MAX = 64;
  localparam int MODE_W = 2;
  localparam int CSEL_W = 2;

  localparam int CLK_MHZ = 100;
  localparam int SAMP_MAX_MHZ = 50;
  localparam int SAMP_MIN_CYC = CLK_MHZ / SAMP_MAX_MHZ;

  localparam logic [11:0] ADDR_IN_MODE = 12'h000;
  localparam logic [11:0] ADDR_IN_CSEL = 12'h004;
  localparam logic [11:0] ADDR_LEND_LEFT = 12'h008;
  localparam logic [11:0] ADDR_LEND_RIGHT = 12'h00c;
  localparam logic [11:0] ADDR_STATE = 12'h010;
  localparam logic [11:0] ADDR_CAPT = 12'h014;
  localparam logic [11:0] ADDR_CKT_LO = 12'h018;
  localparam logic [11:0] ADDR_CKT_HI = 12'h01c;
  localparam logic [11:0] ADDR_TERM_BASE = 12'h100;
  localparam int TERM_MAX = 480;

  localparam logic [31:0] RST_IN_MODE = 32'h0000_0000;
  localparam logic [31:0] RST_IN_CSEL = 32'h0000_0000;
  localparam logic [31:0] RST_LEND = 32'h0000_0000;
  localparam logic [63:0] RST_MASK = 64'h0000_0000_0000_0000;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {MODE_FLOW, MODE_REG, MODE_LATCH} isc_mode_t;
  typedef enum logic [1:0] {CSEL_INV, CSEL_SAMP, CSEL_TERM} isc_csel_t;
  typedef enum logic [1:0] {PH_IDLE, PH_WR, PH_RDW, PH_RDD} isc_phase_t;
endpackage

// >>> core/isc_if.sv
`timescale 1ns/1ps
interface isc_in_if #(parameter int N_IN = 8);
  logic [2*N_IN-1:0] mode;
  logic [2*N_IN-1:0] csel;
  logic clk_term;
  logic samp;
  logic [N_IN-1:0] din;
  logic [N_IN-1:0] capt;
  modport ctl(output mode, output csel, output clk_term, output samp, output din, input capt);
  modport stage(input mode, input csel, input clk_term, input samp, input din, output capt);
endinterface

interface isc_ring_if #(parameter int N_MC = 12);
  logic [N_MC*8-1:0] terms;
  logic [N_MC-1:0] lend_left;
  logic [N_MC-1:0] lend_right;
  logic [N_MC-1:0] state;
  modport ctl(output terms, output lend_left, output lend_right, input state);
  modport ring(input terms, input lend_left, input lend_right, output state);
endinterface

// >>> core/isc_in_stage.sv
`timescale 1ns/1ps
module isc_in_stage #(
  parameter int N_IN = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  isc_in_if.stage io
);
  import isc_pkg::*;

  logic samp_prev_q, samp_prev_d, term_prev_q, term_prev_d;
  logic samp_rise, term_rise;

  always_comb begin
    samp_prev_d = io.samp;
    term_prev_d = io.clk_term;
    samp_rise = io.samp && !samp_prev_q;
    term_rise = io.clk_term && !term_prev_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      samp_prev_q <= 1'b0;
      term_prev_q <= 1'b0;
    end else begin
      samp_prev_q <= samp_prev_d;
      term_prev_q <= term_prev_d;
    end
  end

  for (genvar i = 0; i < N_IN; i++) begin : g_in
    isc_mode_t m;
    isc_csel_t c;
    logic neg_q, neg_d, smp_q, smp_d, pt_q, pt_d, hold_q, hold_d, act, cap;
    assign m = isc_mode_t'(io.mode[2*i +: 2]);
    assign c = isc_csel_t'(io.csel[2*i +: 2]);

    always_comb begin
      case (c)
        CSEL_INV: act = ~hclk;
        CSEL_SAMP: act = io.samp;
        CSEL_TERM: act = io.clk_term;
        default: act = 1'b0;
      endcase
      neg_d = io.din[i];
      smp_d = samp_rise ? io.din[i] : smp_q;
      pt_d = term_rise ? io.din[i] : pt_q;
      // Inverted latch closes at the rising output edge
      hold_d = (c == CSEL_INV || act) ? io.din[i] : hold_q;
      case (m)
        MODE_REG: begin
          case (c)
            CSEL_INV: cap = neg_q;
            CSEL_SAMP: cap = smp_q;
            CSEL_TERM: cap = pt_q;
            default: cap = io.din[i];
          endcase
        end
        MODE_LATCH: cap = act ? io.din[i] : hold_q;
        default: cap = io.din[i];
      endcase
    end

    // Half a period ahead of the output registers
    always_ff @(negedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        neg_q <= 1'b0;
      end else begin
        neg_q <= neg_d;
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        smp_q <= 1'b0;
        pt_q <= 1'b0;
        hold_q <= 1'b0;
      end else begin
        smp_q <= smp_d;
        pt_q <= pt_d;
        hold_q <= hold_d;
      end
    end

    assign io.capt[i] = cap;
  end
endmodule // isc_in_stage

// >>> core/isc_mc_ring.sv
`timescale 1ns/1ps
module isc_mc_ring #(
  parameter int N_MC = 12,
  parameter int RING = 6
) (
  input wire logic hclk,
  input wire logic hresetn,
  isc_ring_if.ring io
);
  import isc_pkg::*;

  logic [N_MC-1:0] g0, g1, sum, state_q, state_d;

  for (genvar i = 0; i < N_MC; i++) begin : g_grp
    assign g0[i] = |io.terms[i*PT_PER_MC +: PT_PER_GRP];
    assign g1[i] = |io.terms[i*PT_PER_MC+PT_PER_GRP +: PT_PER_GRP];
  end

  for (genvar i = 0; i < N_MC; i++) begin : g_mc
    localparam int BASE = (i / RING) * RING;
    localparam int LN = BASE + ((i - BASE + RING - 1) % RING);
    localparam int RN = BASE + ((i - BASE + 1) % RING);
    // Own groups not lent, plus groups lent in by both neighbours
    assign sum[i] = (!io.lend_left[i] && g0[i]) || (!io.lend_right[i] && g1[i])
                    || (io.lend_right[LN] && g1[LN]) || (io.lend_left[RN] && g0[RN]);
  end

  always_comb begin
    state_d = sum;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign io.state = state_q;
endmodule // isc_mc_ring

// >>> core/isc_cell_top.sv
`timescale 1ns/1ps
module isc_cell_top #(
  parameter int N_IN = isc_pkg::N_IN_DEF,
  parameter int N_MC = isc_pkg::N_MC_DEF,
  parameter int RING = isc_pkg::RING_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [N_IN-1:0] pin_in,
  input wire logic samp_clk_in,
  output logic [N_MC-1:0] mc_out
);
  import isc_pkg::*;

  localparam int LIT_W = 2 * (N_IN + N_MC);
  localparam int N_PT = N_MC * PT_PER_MC;
  localparam logic [8:0] TERM_IDX0 = ADDR_TERM_BASE[11:3];

  if (LIT_W > LIT_MAX || N_MC > 32 || 2 * N_IN > 32 || N_PT > TERM_MAX) begin : g_chk_size
    $error("isc_cell_top: array too large for the register map");
  end
  if (RING < 2 || N_MC != 2 * RING) begin : g_chk_ring
    $error("isc_cell_top: cells must form two rings");
  end
  if (SAMP_MIN_CYC < 2) begin : g_chk_samp
    $error("isc_cell_top: clock too slow for the sampling clock");
  end

  isc_in_if #(.N_IN(N_IN)) in_if ();
  isc_ring_if #(.N_MC(N_MC)) ring_if ();

  isc_in_stage #(.N_IN(N_IN)) u_in (
    .hclk(hclk),
    .hresetn(hresetn),
    .io(in_if)
  );

  isc_mc_ring #(.N_MC(N_MC), .RING(RING)) u_ring (
    .hclk(hclk),
    .hresetn(hresetn),
    .io(ring_if)
  );

  // Configuration and array programming
  logic [2*N_IN-1:0] mode_q, mode_d, csel_q, csel_d;
  logic [N_MC-1:0] lendl_q, lendl_d, lendr_q, lendr_d;
  logic [LIT_W-1:0] ckt_q, ckt_d;
  logic [LIT_W-1:0] mask_q [N_PT];
  logic [LIT_W-1:0] mask_d [N_PT];

  // Bus state
  isc_phase_t ph_q, ph_d;
  logic [11:0] addr_q, addr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic accept;

  // Array evaluation
  logic [LIT_W-1:0] lit, raw_lit;
  logic [N_PT-1:0] term;
  logic clk_term;

  // Register decode
  logic [8:0] t_idx;
  logic in_term;
  logic [63:0] t_word, ckt_word;
  logic [31:0] rd_val;

  assign lit = {~ring_if.state, ring_if.state, ~in_if.capt, in_if.capt};
  assign raw_lit = {~ring_if.state, ring_if.state, ~pin_in, pin_in};

  for (genvar t = 0; t < N_PT; t++) begin : g_term
    // An empty term is disabled rather than always true
    assign term[t] = (|mask_q[t]) && ((lit & mask_q[t]) == mask_q[t]);
  end

  // Clock term uses raw pins so a term-clocked latch forms no loop
  assign clk_term = (|ckt_q) && ((raw_lit & ckt_q) == ckt_q);

  assign in_if.mode = mode_q;
  assign in_if.csel = csel_q;
  assign in_if.clk_term = clk_term;
  assign in_if.samp = samp_clk_in;
  assign in_if.din = pin_in;
  assign ring_if.terms = term;
  assign ring_if.lend_left = lendl_q;
  assign ring_if.lend_right = lendr_q;

  assign accept = hsel && hready && htrans[1];
  assign hreadyout = (ph_q != PH_RDW);
  assign hresp = HRESP_OKAY;
  assign hrdata = hrdata_q;
  assign mc_out = ring_if.state;

  always_comb begin
    t_idx = addr_q[11:3] - TERM_IDX0;
    in_term = (addr_q >= ADDR_TERM_BASE) && (32'(t_idx) < N_PT);
    t_word = in_term ? 64'(mask_q[t_idx[$clog2(N_PT)-1:0]]) : RST_MASK;
    ckt_word = 64'(ckt_q);
    if (in_term) begin
      rd_val = addr_q[2] ? t_word[63:32] : t_word[31:0];
    end else begin
      case (addr_q)
        ADDR_IN_MODE: rd_val = 32'(mode_q);
        ADDR_IN_CSEL: rd_val = 32'(csel_q);
        ADDR_LEND_LEFT: rd_val = 32'(lendl_q);
        ADDR_LEND_RIGHT: rd_val = 32'(lendr_q);
        ADDR_STATE: rd_val = 32'(ring_if.state);
        ADDR_CAPT: rd_val = 32'(in_if.capt);
        ADDR_CKT_LO: rd_val = ckt_word[31:0];
        ADDR_CKT_HI: rd_val = ckt_word[63:32];
        default: rd_val = RD_ZERO;
      endcase
    end
  end

  always_comb begin
    case (ph_q)
      PH_RDW: ph_d = PH_RDD;
      default: ph_d = accept ? (hwrite ? PH_WR : PH_RDW) : PH_IDLE;
    endcase
    addr_d = accept ? {haddr[11:2], 2'b00} : addr_q;
    hrdata_d = (ph_q == PH_RDW) ? rd_val : hrdata_q;
  end

  always_comb begin
    logic [63:0] w;
    w = t_word;
    mode_d = mode_q;
    csel_d = csel_q;
    lendl_d = lendl_q;
    lendr_d = lendr_q;
    ckt_d = ckt_q;
    mask_d = mask_q;
    if (ph_q == PH_WR) begin
      if (in_term) begin
        if (addr_q[2]) begin
          w[63:32] = hwdata;
        end else begin
          w[31:0] = hwdata;
        end
        mask_d[t_idx[$clog2(N_PT)-1:0]] = w[LIT_W-1:0];
      end else begin
        case (addr_q)
          ADDR_IN_MODE: mode_d = hwdata[2*N_IN-1:0];
          ADDR_IN_CSEL: csel_d = hwdata[2*N_IN-1:0];
          ADDR_LEND_LEFT: lendl_d = hwdata[N_MC-1:0];
          ADDR_LEND_RIGHT: lendr_d = hwdata[N_MC-1:0];
          ADDR_CKT_LO: begin
            w = ckt_word;
            w[31:0] = hwdata;
            ckt_d = w[LIT_W-1:0];
          end
          ADDR_CKT_HI: begin
            w = ckt_word;
            w[63:32] = hwdata;
            ckt_d = w[LIT_W-1:0];
          end
          default: mode_d = mode_q;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_q <= PH_IDLE;
      addr_q <= 12'h000;
      hrdata_q <= RD_ZERO;
    end else begin
      ph_q <= ph_d;
      addr_q <= addr_d;
      hrdata_q <= hrdata_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= RST_IN_MODE[2*N_IN-1:0];
      csel_q <= RST_IN_CSEL[2*N_IN-1:0];
      lendl_q <= RST_LEND[N_MC-1:0];
      lendr_q <= RST_LEND[N_MC-1:0];
      ckt_q <= RST_MASK[LIT_W-1:0];
      for (int k = 0; k < N_PT; k++) begin
        mask_q[k] <= RST_MASK[LIT_W-1:0];
      end
    end else begin
      mode_q <= mode_d;
      csel_q <= csel_d;
      lendl_q <= lendl_d;
      lendr_q <= lendr_d;
      ckt_q <= ckt_d;
      mask_q <= mask_d;
    end
  end
endmodule // isc_cell_top

// >>> verification/isc_cell_monitor.sv
`timescale 1ns/1ps
module isc_cell_monitor #(
  parameter int N_MC = 12
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [N_MC-1:0] mc_out
);
  import isc_pkg::*;
  logic rd_go;
  logic wr_go;
  logic cfg_d;
  logic cfg_q;
  assign rd_go = hsel && hready && htrans[1] && !hwrite;
  assign wr_go = hsel && hready && htrans[1] && hwrite;
  always_comb cfg_d = cfg_q | wr_go;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cfg_q <= 1'b0;
    else cfg_q <= cfg_d;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  resp_okay_a: assert property (hresp == HRESP_OKAY) else $error("hresp not okay");
  read_wait_a: assert property (rd_go |=> !hreadyout ##1 hreadyout) else $error("read wait");
  write_nowait_a: assert property (wr_go |=> hreadyout) else $error("write stall");
  wait_cause_a: assert property (!hreadyout |-> $past(rd_go)) else $error("stray wait");
  rdata_hold_a: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("hrdata moved");
  unmap_zero_a: assert property (rd_go && haddr[11:8] == 4'h0 && haddr[7:5] != 3'h0
    |-> ##2 hrdata == RD_ZERO) else $error("unmapped read");
  reset_clear_a: assert property (disable iff (1'b0) !hresetn |-> mc_out == '0 && hreadyout)
    else $error("reset values");
  idle_array_a: assert property (!cfg_q |-> mc_out == '0) else $error("array active");
  rd_c: cover property (rd_go);
  wr_c: cover property (wr_go);
  arr_c: cover property (mc_out != '0);
endmodule // isc_cell_monitor

bind isc_cell_top isc_cell_monitor #(.N_MC(N_MC)) i_mon (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mc_out(mc_out));

// >>> verification/isc_src_model.sv
`timescale 1ns/1ps
module isc_src_model (
  input wire logic hclk,
  output logic [7:0] pin_in,
  output logic samp_clk_in
);
  initial begin
    pin_in = 8'h00;
    samp_clk_in = 1'b0;
  end
  task automatic set_pins(input logic [7:0] v);
    @(posedge hclk);
    pin_in <= v;
  endtask
  // Whole cycles only, so the sampling clock stays at or below half the bus rate
  task automatic set_samp(input logic v);
    @(posedge hclk);
    samp_clk_in <= v;
  endtask
endmodule // isc_src_model

// >>> verification/test_input_sync_term_sharing_cell.sv
`timescale 1ns/1ps
module test_input_sync_term_sharing_cell;
  import isc_pkg::*;
  logic hclk = 1'b0;
  logic hresetn;
  logic hsel = 1'b0;
  logic [2:0] hsize = 3'b000;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [7:0] pin_in;
  logic samp_clk_in;
  logic [11:0] mc_out;
  logic cur;
  int n_errors = 0;
  int checks_done = 0;
  always #5 hclk = ~hclk;
  isc_cell_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in),
    .samp_clk_in(samp_clk_in), .mc_out(mc_out));
  isc_src_model i_src (.hclk(hclk), .pin_in(pin_in), .samp_clk_in(samp_clk_in));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    haddr <= a;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, {20'h0_0000, a}, d, x);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, {20'h0_0000, a}, 32'h0000_0000, x);
    check(x, e);
  endtask
  task automatic see(input logic [11:0] e);
    repeat (3) @(posedge hclk);
    #1;
    check({20'h0_0000, mc_out}, {20'h0_0000, e});
  endtask
  function automatic logic [11:0] tm(input int t);
    return 12'h100 + 12'(8 * t);
  endfunction
  task automatic s_reset();
    rd(ADDR_IN_MODE, RST_IN_MODE);
    rd(ADDR_IN_CSEL, RST_IN_CSEL);
    rd(ADDR_LEND_LEFT, RST_LEND);
    rd(12'h020, RD_ZERO);
    see(12'h000);
  endtask
  task automatic s_regs();
    logic [31:0] x;
    wr(ADDR_IN_MODE, 32'hffff_5a5a);
    rd(ADDR_IN_MODE, 32'h0000_5a5a);
    wr(ADDR_IN_CSEL, 32'h0000_a5a5);
    rd(ADDR_IN_CSEL, 32'h0000_a5a5);
    wr(ADDR_LEND_RIGHT, 32'hffff_ffff);
    rd(ADDR_LEND_RIGHT, 32'h0000_0fff);
    wr(ADDR_CKT_HI, 32'hffff_ffff);
    rd(ADDR_CKT_HI, 32'h0000_00ff);
    wr(tm(1) + 12'h004, 32'hffff_ffff);
    rd(tm(1) + 12'h004, 32'h0000_00ff);
    wr(tm(1) + 12'h004, 32'h0000_0000);
    wr(ADDR_CKT_HI, 32'h0000_0000);
    wr(ADDR_LEND_RIGHT, 32'h0000_0000);
    wr(ADDR_IN_CSEL, 32'h0000_0000);
    // Address bits above the register window are ignored
    bus(1'b1, 32'hffff_f000, 32'h0000_0000, x);
    rd(ADDR_IN_MODE, 32'h0000_0000);
  endtask
  task automatic s_input();
    wr(tm(0), 32'h0000_0001);
    i_src.set_pins(8'h01);
    see(12'h001);
    i_src.set_pins(8'h00);
    wr(ADDR_IN_MODE, 32'h0000_0001);
    wr(ADDR_IN_CSEL, 32'h0000_0001);
    i_src.set_pins(8'h01);
    see(12'h000);
    i_src.set_samp(1'b1);
    i_src.set_samp(1'b0);
    see(12'h001);
    i_src.set_pins(8'h00);
    see(12'h001);
    wr(ADDR_IN_MODE, 32'h0000_0002);
    i_src.set_samp(1'b1);
    see(12'h000);
    i_src.set_pins(8'h01);
    see(12'h001);
    i_src.set_samp(1'b0);
    i_src.set_pins(8'h00);
    see(12'h001);
    wr(ADDR_IN_MODE, 32'h0000_0001);
    wr(ADDR_IN_CSEL, 32'h0000_0002);
    wr(ADDR_CKT_LO, 32'h0000_0002);
    i_src.set_pins(8'h02);
    see(12'h000);
    i_src.set_pins(8'h01);
    see(12'h000);
    i_src.set_pins(8'h03);
    see(12'h001);
    wr(ADDR_IN_CSEL, 32'h0000_0000);
    i_src.set_pins(8'h00);
    see(12'h000);
    i_src.set_pins(8'h01);
    @(posedge hclk);
    #1;
    check({31'h0, mc_out[0]}, 32'h0000_0001);
    wr(ADDR_IN_MODE, 32'h0000_0000);
    wr(tm(0), 32'h0000_0000);
  endtask
  task automatic s_lend();
    wr(tm(44), 32'h0000_0001);
    see(12'h020);
    wr(ADDR_LEND_RIGHT, 32'h0000_0020);
    see(12'h001);
    wr(tm(48), 32'h0000_0001);
    wr(ADDR_LEND_LEFT, 32'h0000_0040);
    see(12'h801);
    wr(tm(8), 32'h0000_0001);
    wr(tm(12), 32'h0000_0001);
    wr(ADDR_LEND_LEFT, 32'h0000_0042);
    wr(ADDR_LEND_RIGHT, 32'h0000_0022);
    see(12'h805);
    rd(ADDR_STATE, 32'h0000_0805);
    rd(ADDR_CAPT, 32'h0000_0001);
    wr(tm(44), 32'h0000_0000);
    see(12'h805);
  endtask
  task automatic s_state();
    wr(tm(24), 32'h8000_0000);
    @(posedge hclk);
    #1;
    cur = mc_out[3];
    @(posedge hclk);
    #1;
    check({31'h0, mc_out[3]}, {31'h0, ~cur});
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    hresetn <= 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    s_reset();
    s_regs();
    s_input();
    s_lend();
    s_state();
    complete_run();
  end
  initial begin
    #100000;
    n_errors++;
    complete_run();
  end
endmodule // test_input_sync_term_sharing_cell
